// File: src/cch_pkg.sv
package cch_pkg;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int MS_PER_S = 1000;
  localparam int S_PER_MIN = 60;
  localparam int COLD_MIN = 15;
  localparam int COLD_S = COLD_MIN * S_PER_MIN;
  localparam int WIN_MIN = 5;
  localparam int WIN_S = WIN_MIN * S_PER_MIN;
  localparam int FMUTE_MS = 10;
  localparam int FMUTE_CYC = CLK_HZ / MS_PER_S * FMUTE_MS;
  localparam int SEC_CYC = CLK_HZ;
  localparam logic [2:0] FAULT_LIMIT = 3'h5;
  // ****************************************************************
  // Settings grid and reset values
  // ****************************************************************
  localparam logic [33:0] BAND_MIN_FREQ = 34'h0_0078_8B60;
  localparam logic [33:0] BAND_MAX_FREQ = 34'h0_0080_2C80;
  localparam logic [33:0] FREQ_STEP = 34'h0_0000_007D;
  localparam logic [33:0] ATT_MIN = 34'h0_0000_0000;
  localparam logic [33:0] ATT_MAX = 34'h0_0000_09C4;
  localparam logic [33:0] ATT_STEP = 34'h0_0000_0019;
  localparam logic [11:0] ATT_RST = 12'h3E8;
  localparam logic [23:0] IF_LO_MHZ = 24'h00_0046;
  localparam logic [23:0] IF_HI_MHZ = 24'h00_008C;
  localparam logic [23:0] ACC_SAT = 24'h19_9999;
  localparam logic [1:0] FREQ_PLACES = 2'h3;
  localparam logic [1:0] ATT_PLACES = 2'h2;
  localparam logic [1:0] MST_OFF = 2'h0;
  localparam logic [1:0] MST_ON = 2'h1;
  localparam logic [1:0] MST_COLD = 2'h2;
  // ****************************************************************
  // Characters and command names
  // ****************************************************************
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_US = 8'h5F;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_Z = 8'h5A;
  localparam logic [7:0] CH_LA = 8'h61;
  localparam logic [7:0] CH_LZ = 8'h7A;
  localparam logic [7:0] CASE_OFS = 8'h20;
  localparam logic [23:0] CMD_FRE = 24'h46_5245;
  localparam logic [23:0] CMD_IFF = 24'h49_4646;
  localparam logic [23:0] CMD_ATT = 24'h41_5454;
  localparam logic [23:0] CMD_CLD = 24'h43_4C44;
  localparam logic [23:0] CMD_MUT = 24'h4D_5554;
  localparam logic [23:0] CMD_CMM = 24'h43_4D4D;
  localparam logic [23:0] CMD_CRM = 24'h43_524D;
  localparam logic [23:0] CMD_AFR = 24'h41_4652;
  localparam logic [23:0] TXT_ON = 24'h00_4F4E;
  localparam logic [23:0] TXT_OFF = 24'h4F_4646;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] ADDR_RX = 12'h000;
  localparam logic [11:0] ADDR_RSTAT = 12'h004;
  localparam logic [11:0] ADDR_RCMD = 12'h008;
  localparam logic [11:0] ADDR_RVAL = 12'h00C;
  localparam logic [11:0] ADDR_SET = 12'h010;
  localparam logic [11:0] ADDR_FREQ = 12'h014;
  localparam logic [11:0] ADDR_ATT = 12'h018;
  localparam int RS_VALID = 0;
  localparam int RS_ERR = 1;
  localparam int ST_MUTE = 0;
  localparam int ST_CLD = 1;
  localparam int ST_CMM = 2;
  localparam int ST_CRM = 3;
  localparam int ST_AFR = 4;
  localparam int ST_IF140 = 5;
  localparam int ST_OUT = 6;
  localparam int ST_MST = 7;
  typedef enum logic {PS_NAME, PS_ARG} cch_ps_e;
endpackage

// File: src/cch_top.sv
// Our own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
// Function
// - Accept 7900-8400 MHz frequency on 125 kHz grid
// - Frequency resets to band minimum
// - IF select accepts only 140 or 70
// - IF select resets to 70 MHz
// - IF change mutes like RF change
// - Attenuation 0-25 dB in 0.25 dB steps
// - Attenuation resets to 10.00 dB
// - Cold start mutes until 15 minutes after reset, resets off
// - Cold start refused in redundant system
// - RF mute setting resets to on
// - Mute query returns on, off or cold
// - Mute mode off mutes every frequency change
// - Mute mode on keeps mute across change
// - Redundancy mute on copies primary mute state
// - Redundancy mute off unmutes on switchover
// - Recovery on mutes on fault, unmutes after
// - Recovery off keeps mute until mute off
// - Over five repeats disables recovery, stays muted
module cch_top #(
  parameter int SEC_CYC = cch_pkg::SEC_CYC,
  parameter int FMUTE_CYC = cch_pkg::FMUTE_CYC,
  parameter int COLD_S = cch_pkg::COLD_S,
  parameter int WIN_S = cch_pkg::WIN_S,
  parameter int NFAULT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dual_if_opt,
  input wire logic redundant_mode,
  input wire logic switchover,
  input wire logic primary_mute,
  input wire logic [NFAULT-1:0] fault_in,
  output logic mute_out,
  output logic [23:0] rf_freq_khz,
  output logic [11:0] att_cdb,
  output logic if_sel_140
);
  import cch_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [7:0] cch_upcase(input logic [7:0] c);
    if (c >= CH_LA && c <= CH_LZ) begin
      cch_upcase = c - CASE_OFS;
    end else begin
      cch_upcase = c;
    end
  endfunction

  // Scales a decimal digit string to p fixed places; too many places fails.
  function automatic logic [33:0] cch_scale(input logic [23:0] v, input logic [1:0] f,
                                            input logic [1:0] p);
    logic [33:0] w;
    w = {10'h000, v};
    if (f > p) begin
      cch_scale = '1;
    end else begin
      case (2'(p - f))
        2'h0: cch_scale = w;
        2'h1: cch_scale = w * 34'h0_0000_000A;
        2'h2: cch_scale = w * 34'h0_0000_0064;
        default: cch_scale = w * 34'h0_0000_03E8;
      endcase
    end
  endfunction

  function automatic logic cch_grid(input logic [33:0] v, input logic [33:0] lo,
                                    input logic [33:0] hi, input logic [33:0] st);
    cch_grid = (v >= lo) && (v <= hi) && ((v % st) == 34'h0_0000_0000);
  endfunction

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic [23:0] resp_cmd_reg;
  logic [33:0] resp_val_reg;
  logic resp_valid_reg, resp_err_reg;
  logic user_mute_reg, cld_on_reg, cmm_on_reg, crm_on_reg, afr_on_reg;
  logic fault_mute_reg, cold_run, cold_active;
  logic [1:0] mst;
  logic [31:0] set_word;
  logic acc_stb, rx_stb, rstat_rd;

  assign acc_stb = psel && penable && pready;
  assign rx_stb = acc_stb && pwrite && (paddr == ADDR_RX);
  assign rstat_rd = acc_stb && !pwrite && (paddr == ADDR_RSTAT);

  always_comb begin
    set_word = 32'h0000_0000;
    set_word[ST_MUTE] = user_mute_reg;
    set_word[ST_CLD] = cld_on_reg;
    set_word[ST_CMM] = cmm_on_reg;
    set_word[ST_CRM] = crm_on_reg;
    set_word[ST_AFR] = afr_on_reg;
    set_word[ST_IF140] = if_sel_140;
    set_word[ST_OUT] = mute_out;
    set_word[ST_MST +: 2] = mst;
  end

  // Ready follows one cycle after setup, so read data comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
        if (paddr == ADDR_RX) begin
          pslverr <= !pwrite;
        end else if (paddr == ADDR_RSTAT && !pwrite) begin
          prdata[RS_VALID] <= resp_valid_reg;
          prdata[RS_ERR] <= resp_err_reg;
        end else if (paddr == ADDR_RCMD && !pwrite) begin
          prdata[23:0] <= resp_cmd_reg;
        end else if (paddr == ADDR_RVAL && !pwrite) begin
          prdata <= resp_val_reg[31:0];
        end else if (paddr == ADDR_SET && !pwrite) begin
          prdata <= set_word;
        end else if (paddr == ADDR_FREQ && !pwrite) begin
          prdata[23:0] <= rf_freq_khz;
        end else if (paddr == ADDR_ATT && !pwrite) begin
          prdata[11:0] <= att_cdb;
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // Character parser
  // ****************************************************************
  cch_ps_e ps_reg;
  logic [23:0] name_reg, txt_reg, acc_reg;
  logic [1:0] frac_reg;
  logic dot_reg, has_dig_reg, has_txt_reg, bad_reg, exec_stb;
  logic [1:0] alen_reg;
  logic [7:0] ch;

  assign ch = cch_upcase(pwdata[7:0]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_reg <= PS_NAME;
      name_reg <= 24'h00_0000;
      txt_reg <= 24'h00_0000;
      acc_reg <= 24'h00_0000;
      frac_reg <= 2'h0;
      alen_reg <= 2'h0;
      dot_reg <= 1'b0;
      has_dig_reg <= 1'b0;
      has_txt_reg <= 1'b0;
      bad_reg <= 1'b0;
      exec_stb <= 1'b0;
    end else begin
      exec_stb <= rx_stb && (ch == CH_CR);
      if (exec_stb) begin
        ps_reg <= PS_NAME;
        name_reg <= 24'h00_0000;
        txt_reg <= 24'h00_0000;
        acc_reg <= 24'h00_0000;
        frac_reg <= 2'h0;
        alen_reg <= 2'h0;
        dot_reg <= 1'b0;
        has_dig_reg <= 1'b0;
        has_txt_reg <= 1'b0;
        bad_reg <= 1'b0;
      end else if (rx_stb && ch != CH_CR) begin
        case (ps_reg)
          PS_NAME: begin
            if (ch == CH_US) begin
              ps_reg <= PS_ARG;
            end else begin
              name_reg <= {name_reg[15:0], ch};
            end
          end
          default: begin
            if (ch >= CH_0 && ch <= CH_9) begin
              has_dig_reg <= 1'b1;
              if (acc_reg > ACC_SAT || (dot_reg && frac_reg == 2'h3)) begin
                bad_reg <= 1'b1;
              end else begin
                acc_reg <= 24'(acc_reg * 24'h00_000A + {16'h0000, ch - CH_0});
                if (dot_reg) begin
                  frac_reg <= frac_reg + 2'h1;
                end
              end
            end else if (ch == CH_DOT) begin
              bad_reg <= bad_reg || dot_reg;
              dot_reg <= 1'b1;
            end else if (ch >= CH_A && ch <= CH_Z && alen_reg != 2'h3) begin
              has_txt_reg <= 1'b1;
              alen_reg <= alen_reg + 2'h1;
              txt_reg <= {txt_reg[15:0], ch};
            end else begin
              bad_reg <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic num_ok, is_on, is_off, is_query, cmd_ok, chg_evt;
  logic [33:0] fk, ak, rval;

  always_comb begin
    num_ok = has_dig_reg && !has_txt_reg && !bad_reg;
    is_on = has_txt_reg && !has_dig_reg && !dot_reg && !bad_reg && txt_reg == TXT_ON;
    is_off = has_txt_reg && !has_dig_reg && !dot_reg && !bad_reg && txt_reg == TXT_OFF;
    is_query = !has_dig_reg && !has_txt_reg && !dot_reg && !bad_reg && ps_reg == PS_ARG;
    fk = cch_scale(acc_reg, frac_reg, FREQ_PLACES);
    ak = cch_scale(acc_reg, frac_reg, ATT_PLACES);
    cmd_ok = 1'b0;
    if (name_reg == CMD_FRE) begin
      cmd_ok = is_query || (num_ok && cch_grid(fk, BAND_MIN_FREQ, BAND_MAX_FREQ,
                                               FREQ_STEP));
    end else if (name_reg == CMD_IFF) begin
      cmd_ok = dual_if_opt && (is_query || (num_ok && frac_reg == 2'h0 &&
               (acc_reg == IF_LO_MHZ || acc_reg == IF_HI_MHZ)));
    end else if (name_reg == CMD_ATT) begin
      cmd_ok = is_query || (num_ok && cch_grid(ak, ATT_MIN, ATT_MAX, ATT_STEP));
    end else if (name_reg == CMD_CLD) begin
      cmd_ok = !redundant_mode && (is_query || is_on || is_off);
    end else if (name_reg == CMD_MUT || name_reg == CMD_CMM ||
                 name_reg == CMD_CRM || name_reg == CMD_AFR) begin
      cmd_ok = is_query || is_on || is_off;
    end
  end

  // Echo value after the command has been applied.
  always_comb begin
    rval = 34'h0_0000_0000;
    if (name_reg == CMD_FRE) begin
      rval = (cmd_ok && !is_query) ? fk : {10'h000, rf_freq_khz};
    end else if (name_reg == CMD_IFF) begin
      rval = {10'h000, (cmd_ok && !is_query) ? acc_reg :
              (if_sel_140 ? IF_HI_MHZ : IF_LO_MHZ)};
    end else if (name_reg == CMD_ATT) begin
      rval = (cmd_ok && !is_query) ? ak : {22'h00_0000, att_cdb};
    end else if (name_reg == CMD_MUT) begin
      rval[1:0] = is_query ? mst : ((cmd_ok ? is_on : user_mute_reg) ? MST_ON : MST_OFF);
    end else if (name_reg == CMD_CLD) begin
      rval[0] = (cmd_ok && !is_query) ? is_on : cld_on_reg;
    end else if (name_reg == CMD_CMM) begin
      rval[0] = (cmd_ok && !is_query) ? is_on : cmm_on_reg;
    end else if (name_reg == CMD_CRM) begin
      rval[0] = (cmd_ok && !is_query) ? is_on : crm_on_reg;
    end else if (name_reg == CMD_AFR) begin
      rval[0] = (cmd_ok && !is_query) ? is_on : afr_on_reg;
    end
  end

  // ****************************************************************
  // Settings and confirmation
  // ****************************************************************
  logic afr_trip;
  logic do_set;

  assign do_set = exec_stb && cmd_ok && !is_query;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rf_freq_khz <= BAND_MIN_FREQ[23:0];
      if_sel_140 <= 1'b0;
      att_cdb <= ATT_RST;
      cld_on_reg <= 1'b0;
      cmm_on_reg <= 1'b0;
      crm_on_reg <= 1'b0;
      afr_on_reg <= 1'b1;
      chg_evt <= 1'b0;
    end else begin
      chg_evt <= 1'b0;
      if (do_set && name_reg == CMD_FRE) begin
        rf_freq_khz <= fk[23:0];
        chg_evt <= 1'b1;
      end
      if (do_set && name_reg == CMD_IFF) begin
        if_sel_140 <= (acc_reg == IF_HI_MHZ);
        chg_evt <= 1'b1;
      end
      if (do_set && name_reg == CMD_ATT) begin
        att_cdb <= ak[11:0];
      end
      if (do_set && name_reg == CMD_CLD) begin
        cld_on_reg <= is_on;
      end
      if (do_set && name_reg == CMD_CMM) begin
        cmm_on_reg <= is_on;
      end
      if (do_set && name_reg == CMD_CRM) begin
        crm_on_reg <= is_on;
      end
      if (afr_trip) begin
        afr_on_reg <= 1'b0;
      end else if (do_set && name_reg == CMD_AFR) begin
        afr_on_reg <= is_on;
      end
    end
  end

  // Host mute command wins over a switchover landing in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_mute_reg <= 1'b1;
    end else if (do_set && name_reg == CMD_MUT) begin
      user_mute_reg <= is_on;
    end else if (switchover) begin
      user_mute_reg <= crm_on_reg ? primary_mute : 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resp_valid_reg <= 1'b0;
      resp_err_reg <= 1'b0;
      resp_cmd_reg <= 24'h00_0000;
      resp_val_reg <= 34'h0_0000_0000;
    end else if (exec_stb) begin
      resp_valid_reg <= 1'b1;
      resp_err_reg <= !cmd_ok;
      resp_cmd_reg <= name_reg;
      resp_val_reg <= rval;
    end else if (rstat_rd) begin
      resp_valid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Timers
  // ****************************************************************
  logic [31:0] sec_div, cold_sec, win_sec, fmute_cnt;
  logic sec_tick, win_tick;

  assign sec_tick = (sec_div == 32'(SEC_CYC - 1));
  assign win_tick = sec_tick && (win_sec == 32'(WIN_S - 1));
  assign cold_run = (cold_sec < 32'(COLD_S));
  assign cold_active = cld_on_reg && cold_run;
  assign mst = cold_active ? MST_COLD : (mute_out ? MST_ON : MST_OFF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_div <= 32'h0000_0000;
      cold_sec <= 32'h0000_0000;
      win_sec <= 32'h0000_0000;
    end else begin
      sec_div <= sec_tick ? 32'h0000_0000 : sec_div + 32'h0000_0001;
      if (sec_tick && cold_run) begin
        cold_sec <= cold_sec + 32'h0000_0001;
      end
      if (sec_tick) begin
        win_sec <= win_tick ? 32'h0000_0000 : win_sec + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fmute_cnt <= 32'h0000_0000;
    end else if (chg_evt && !cmm_on_reg) begin
      fmute_cnt <= 32'(FMUTE_CYC);
    end else if (fmute_cnt != 32'h0000_0000) begin
      fmute_cnt <= fmute_cnt - 32'h0000_0001;
    end
  end

  // ****************************************************************
  // Fault handling and output mute
  // ****************************************************************
  logic [NFAULT-1:0] fault_q;
  logic [2:0] occ_cnt [NFAULT];
  logic [NFAULT-1:0] trip_vec;

  always_comb begin
    for (int i = 0; i < NFAULT; i++) begin
      trip_vec[i] = fault_in[i] && !fault_q[i] && (occ_cnt[i] >= FAULT_LIMIT);
    end
  end
  assign afr_trip = afr_on_reg && (|trip_vec);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_q <= '0;
      for (int i = 0; i < NFAULT; i++) begin
        occ_cnt[i] <= 3'h0;
      end
    end else begin
      fault_q <= fault_in;
      for (int i = 0; i < NFAULT; i++) begin
        if (fault_in[i] && !fault_q[i] && occ_cnt[i] <= FAULT_LIMIT) begin
          occ_cnt[i] <= occ_cnt[i] + 3'h1;
        end else if (win_tick) begin
          occ_cnt[i] <= 3'h0;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_mute_reg <= 1'b0;
    end else if (|fault_in) begin
      fault_mute_reg <= 1'b1;
    end else if (afr_on_reg && !afr_trip) begin
      fault_mute_reg <= 1'b0;
    end else if (do_set && name_reg == CMD_MUT && is_off) begin
      fault_mute_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mute_out <= 1'b1;
    end else begin
      mute_out <= user_mute_reg || fault_mute_reg || cold_active ||
                  (fmute_cnt != 32'h0000_0000);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  AST_FREQ_GRID: assert property (@(posedge pclk) disable iff (!presetn)
    cch_grid({10'h000, rf_freq_khz}, BAND_MIN_FREQ, BAND_MAX_FREQ, FREQ_STEP))
    else $error("frequency off range or grid");
  AST_ATT_GRID: assert property (@(posedge pclk) disable iff (!presetn)
    cch_grid({22'h00_0000, att_cdb}, ATT_MIN, ATT_MAX, ATT_STEP))
    else $error("attenuation off range or grid");
  AST_IF_OPT: assert property (@(posedge pclk) disable iff (!presetn)
    !$stable(if_sel_140) |-> $past(dual_if_opt) && $past(exec_stb))
    else $error("IF select changed without option");
  AST_COLD_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
    cold_active |-> mst == MST_COLD ##1 mute_out)
    else $error("cold start not muting");
  AST_CLD_RED: assert property (@(posedge pclk) disable iff (!presetn)
    exec_stb && name_reg == CMD_CLD && redundant_mode |=> resp_err_reg && $stable(cld_on_reg))
    else $error("cold start taken in redundant system");
  AST_CHG_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
    chg_evt && !cmm_on_reg |=> fmute_cnt == 32'(FMUTE_CYC) ##1 mute_out)
    else $error("frequency change did not mute");
  AST_CMM_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
    chg_evt && cmm_on_reg && fmute_cnt == 32'h0000_0000 |=> fmute_cnt == 32'h0000_0000)
    else $error("mute mode on still muted on change");
  AST_SW_COPY: assert property (@(posedge pclk) disable iff (!presetn)
    switchover && crm_on_reg && !do_set |=> user_mute_reg == $past(primary_mute))
    else $error("switchover did not copy primary mute");
  AST_SW_UNMUTE: assert property (@(posedge pclk) disable iff (!presetn)
    switchover && !crm_on_reg && !do_set |=> !user_mute_reg)
    else $error("switchover did not unmute");
  AST_FAULT_MUTE: assert property (@(posedge pclk) disable iff (!presetn)
    (|fault_in) |=> fault_mute_reg ##1 mute_out)
    else $error("fault did not mute");
  AST_AFR_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    fault_mute_reg && !afr_on_reg && !(|fault_in) && !do_set |=> fault_mute_reg)
    else $error("fault mute released without command");
  AST_AFR_TRIP: assert property (@(posedge pclk) disable iff (!presetn)
    afr_trip |=> !afr_on_reg ##1 mute_out)
    else $error("repeated fault did not disable recovery");
  AST_CONFIRM: assert property (@(posedge pclk) disable iff (!presetn)
    exec_stb |=> resp_valid_reg && resp_cmd_reg == $past(name_reg))
    else $error("command not confirmed");
  AST_REJECT: assert property (@(posedge pclk) disable iff (!presetn)
    exec_stb && !cmd_ok |=> $stable(rf_freq_khz) && $stable(att_cdb))
    else $error("rejected value changed a setting");
  COV_FREQ_SET: cover property (@(posedge pclk) do_set && name_reg == CMD_FRE);
  COV_REJECT: cover property (@(posedge pclk) exec_stb && !cmd_ok);
  COV_TRIP: cover property (@(posedge pclk) afr_trip);
  COV_SWITCH: cover property (@(posedge pclk) switchover && crm_on_reg);
endmodule

// File: verification/cch_env.sv
`timescale 1ns/100ps
module cch_env (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] fault_req,
  input wire logic swo_req,
  output logic [3:0] fault_in,
  output logic switchover
);
  logic swo_reg;
  // Fault lines follow the request; a switchover is one pulse per request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_in <= 4'h0;
      swo_reg <= 1'b0;
      switchover <= 1'b0;
    end else begin
      fault_in <= fault_req;
      swo_reg <= swo_req;
      switchover <= swo_req & ~swo_reg;
    end
  end
endmodule

// File: verification/converter_config_command_handler_bench.sv
`timescale 1ns/100ps
module converter_config_command_handler_bench;
  import cch_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, dual = 1, red = 0, pm = 1;
  logic [11:0] paddr = 12'h000, att_cdb;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, se, mute_out, if_sel_140, switchover, swo_req = 0;
  logic [3:0] fault_in, fault_req = 4'h0;
  logic [23:0] rf_freq_khz;
  int err_count = 0, comparisons = 0;
  always #10 pclk = ~pclk;
  cch_top #(.SEC_CYC(10), .FMUTE_CYC(8), .COLD_S(20), .WIN_S(4)) cch_top_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dual_if_opt(dual),
    .redundant_mode(red), .switchover(switchover), .primary_mute(pm), .fault_in(fault_in),
    .mute_out(mute_out), .rf_freq_khz(rf_freq_khz), .att_cdb(att_cdb),
    .if_sel_140(if_sel_140));
  cch_env cch_env_i (.pclk(pclk), .presetn(presetn), .fault_req(fault_req), .swo_req(swo_req),
    .fault_in(fault_in), .switchover(switchover));
  task automatic w(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input string s, input logic err);
    foreach (s[i]) apb(1, ADDR_RX, {24'h0, s[i]});
    apb(1, ADDR_RX, {24'h0, CH_CR});
    apb(0, ADDR_RSTAT, 32'h0);
    check(rd, {30'h0, err, 1'b1});
  endtask
  task automatic close_out();
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    w(20000);
    err_count++;
    close_out();
  end
  initial begin
    w(10);
    presetn <= 1;
    w(1);
    check(rf_freq_khz, 32'h0078_8B60);
    check(att_cdb, 32'h0000_03E8);
    check(if_sel_140, 32'h0);
    apb(0, ADDR_SET, 32'h0);
    check(rd, 32'h0000_00D1);
    check(se, 32'h0);
    apb(0, ADDR_RX, 32'h0);
    check(se, 32'h1);
    cmd("MUT_OFF", 0);
    check(mute_out, 32'h0);
    cmd("FRE_8000.125", 0);
    check(mute_out, 32'h1);
    check(rf_freq_khz, 32'h007A_127D);
    apb(0, ADDR_RCMD, 32'h0);
    check(rd, {8'h00, CMD_FRE});
    apb(0, ADDR_RVAL, 32'h0);
    check(rd, 32'h007A_127D);
    w(12);
    check(mute_out, 32'h0);
    cmd("FRE_8400.001", 1);
    check(rf_freq_khz, 32'h007A_127D);
    cmd("CMM_ON", 0);
    cmd("FRE_7900", 0);
    check(mute_out, 32'h0);
    cmd("FRE_8400", 0);
    check(rf_freq_khz, 32'h0080_2C80);
    cmd("CMM_OFF", 0);
    cmd("IFF_140", 0);
    check(if_sel_140, 32'h1);
    check(mute_out, 32'h1);
    cmd("IFF_100", 1);
    dual <= 0;
    cmd("IFF_70", 1);
    check(if_sel_140, 32'h1);
    dual <= 1;
    cmd("IFF_070", 0);
    check(if_sel_140, 32'h0);
    w(12);
    cmd("ATT_25.00", 0);
    check(att_cdb, 32'h0000_09C4);
    cmd("ATT_10.1", 1);
    check(att_cdb, 32'h0000_09C4);
    fault_req <= 4'h1;
    w(5);
    check(mute_out, 32'h1);
    fault_req <= 4'h0;
    w(5);
    check(mute_out, 32'h0);
    cmd("AFR_OFF", 0);
    fault_req <= 4'h2;
    w(5);
    fault_req <= 4'h0;
    w(5);
    check(mute_out, 32'h1);
    cmd("MUT_OFF", 0);
    check(mute_out, 32'h0);
    cmd("MUT_ON", 0);
    swo_req <= 1;
    w(5);
    check(mute_out, 32'h0);
    swo_req <= 0;
    cmd("MUT_", 0);
    apb(0, ADDR_RVAL, 32'h0);
    check(rd, 32'h0);
    red <= 1;
    cmd("CLD_ON", 1);
    presetn <= 0;
    red <= 0;
    w(10);
    presetn <= 1;
    w(1);
    check(rf_freq_khz, 32'h0078_8B60);
    check(if_sel_140, 32'h0);
    repeat (6) begin
      fault_req <= 4'h1;
      w(1);
      fault_req <= 4'h0;
      w(1);
    end
    w(4);
    apb(0, ADDR_SET, 32'h0);
    check(rd, 32'h0000_00C1);
    cmd("MUT_OFF", 0);
    cmd("CLD_ON", 0);
    check(mute_out, 32'h1);
    cmd("MUT_", 0);
    apb(0, ADDR_RVAL, 32'h0);
    check(rd, 32'h0000_0002);
    w(130);
    check(mute_out, 32'h0);
    cmd("CRM_ON", 0);
    swo_req <= 1;
    w(5);
    check(mute_out, 32'h1);
    close_out();
  end
endmodule
